// ===== cod_pkg.sv
// Constants, types and register map for the CPU operand decoder
package cod_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_OPCODE  = 8'h04;
  localparam logic [7:0] OFF_BASE    = 8'h08;
  localparam logic [7:0] OFF_INDEX   = 8'h0C;
  localparam logic [7:0] OFF_ACCSP   = 8'h10;
  localparam logic [7:0] OFF_CLOCKS  = 8'h14;
  localparam logic [7:0] OFF_NEXTPC  = 8'h18;
  localparam logic [7:0] OFF_FARPTR  = 8'h1C;
  localparam logic [7:0] OFF_TEMPAB  = 8'h20;
  localparam logic [7:0] OFF_TEMPC   = 8'h24;
  localparam logic [7:0] OFF_FLAGS   = 8'h28;
  localparam logic [7:0] OFF_MEMDATA = 8'h2C;
  localparam logic [7:0] OFF_STATUS  = 8'h30;
  localparam logic [7:0] OFF_EA      = 8'h34;
  localparam logic [7:0] OFF_CYCLES  = 8'h38;
  localparam logic [7:0] OFF_STACK   = 8'h3C;
  localparam logic [7:0] OFF_BLOCK   = 8'h40;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_GO    = 0;
  localparam int CTRL_TAKEN = 1;
  localparam int CTRL_COND  = 2;
  localparam int CTRL_FLOAT = 3;
  localparam int CTRL_FAR   = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Opcode field values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  MOD_NODISP = 2'h0;
  localparam logic [1:0]  MOD_DISP8  = 2'h1;
  localparam logic [1:0]  MOD_DISP16 = 2'h2;
  localparam logic [1:0]  MOD_REG    = 2'h3;
  localparam logic [2:0]  MEM_DIRECT = 3'h6;
  localparam logic [15:0] ODD_WORD_CLOCKS = 16'h0004;
  localparam int          NUM_FLAGS  = 6;

  // Segment register identities
  typedef enum logic [1:0] {
    SEG_DATA1   = 2'b00,
    SEG_PROGRAM = 2'b01,
    SEG_STACK   = 2'b10,
    SEG_DATA0   = 2'b11
  } cod_seg_t;

  // Per-flag action codes
  typedef enum logic [2:0] {
    FL_KEEP    = 3'b000,
    FL_CLEAR   = 3'b001,
    FL_SET     = 3'b010,
    FL_RESULT  = 3'b011,
    FL_UNDEF   = 3'b100,
    FL_RESTORE = 3'b101
  } cod_flact_t;

  // Decoder state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DONE = 2'b10
  } cod_state_t;

  // Decoded operand fields
  typedef struct packed {
    logic       size_word;
    logic       imm16;
    logic       is_mem;
    logic       direct;
    logic [1:0] disp_len;
    logic [3:0] gpr;
    cod_seg_t   seg;
  } cod_dec_t;

endpackage : cod_pkg

// ===== cod_decoder.sv
// APB-mapped instruction operand decoder with clock-count calculator
`timescale 1ns/1ps

// Functional notes
// (RULE_01) Size bit 0 selects byte operands, 1 selects word operands.
// (RULE_02) Sign/size pair 01 or 11 gives 16-bit immediate, else 8-bit.
// (RULE_03) Form 00/01/10 is memory with 0/8/16-bit offset; 11 is register.
// (RULE_04) Storage field picks address base; code 110 with form 00 is direct.
// (RULE_05) Register form picks byte or word register by size bit and code.
// (RULE_06) Segment codes 00..11 map data1, program, stack, data0.
// (RULE_07) Each odd-address word transfer adds four clocks.
// (RULE_08) Memory operands use first count for bytes, second for words.
// (RULE_09) Conditional transfers use first count if taken, second if not.
// (RULE_10) Listed counts assume a full queue; fetch stalls add on top.
// (RULE_11) Short branch target is next address plus signed byte -128..+127.
// (RULE_12) Each flag follows one of six actions, restore included.
// (RULE_13) Scratch registers temp_a, temp_b, temp_c are 16 bits each.
// (RULE_14) Lookup operand addresses a 256-byte table with an 8-bit index.
// (RULE_15) Stack discard count drops up to 64 K bytes after return.
// (RULE_16) Block source uses source_index, destination uses dest_index.
// (RULE_17) Far indirect pointer double word gives new offset and segment.
// (RULE_18) Float op code bits pass through undecoded.
// (RULE_19) Read data of a float instruction's memory cycle is ignored.
module cod_decoder (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Decoder status
  output logic             dec_done,
  output logic      [5:0]  float_op_code
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Sign-extend a byte displacement to a word
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  // Apply one flag action to a flag bit
  function automatic logic flag_apply(input logic [2:0] act,
                                      input logic old_v,
                                      input logic res_v,
                                      input logic sav_v);
    case (act)
      cod_pkg::FL_CLEAR:   flag_apply = 1'b0;
      cod_pkg::FL_SET:     flag_apply = 1'b1;
      cod_pkg::FL_RESULT:  flag_apply = res_v;
      cod_pkg::FL_RESTORE: flag_apply = sav_v;
      default:             flag_apply = old_v;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]          ctrl_q;
  logic [31:0]          opcode_q;
  logic [31:0]          base_q;
  logic [31:0]          index_q;
  logic [31:0]          accsp_q;
  logic [31:0]          clocks_q;
  logic [31:0]          nextpc_q;
  logic [31:0]          farptr_q;
  logic [15:0]          temp_a_q;
  logic [15:0]          temp_b_q;
  logic [15:0]          temp_c_q;
  logic [31:0]          flags_cfg_q;
  logic [31:0]          memdata_q;
  logic [5:0]           flags_q;
  cod_pkg::cod_dec_t    dec_q;
  logic [15:0]          ea_q;
  logic [15:0]          target_q;
  logic [15:0]          cycles_q;
  logic [15:0]          lookup_q;
  logic [15:0]          sp_after_q;
  cod_pkg::cod_state_t  state_q;
  cod_pkg::cod_state_t  state_d;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access   = psel && penable;
  wire logic wr_en    = access && pwrite;
  wire logic rd_en    = access && !pwrite;
  wire logic mapped   = (paddr[1:0] == 2'h0)
                        && (paddr <= cod_pkg::OFF_BLOCK);
  wire logic wr_ctrl  = wr_en && paddr == cod_pkg::OFF_CTRL;
  wire logic go       = wr_ctrl && pwdata[cod_pkg::CTRL_GO];

  // Zero wait states; misaligned or out-of-map access errors
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire logic [7:0]  op_byte   = opcode_q[7:0];
  wire logic [7:0]  form_byte = opcode_q[15:8];
  wire logic [15:0] disp_word = opcode_q[31:16];
  wire logic        size_bit  = op_byte[0];
  wire logic        extend_bit = op_byte[1];
  wire logic [1:0]  addr_form = form_byte[7:6];
  wire logic [2:0]  mid_field = form_byte[5:3];
  wire logic [2:0]  low_field = form_byte[2:0];
  wire logic        is_mem    = addr_form != cod_pkg::MOD_REG; // [RULE_03]
  wire logic        is_direct = addr_form == cod_pkg::MOD_NODISP
                                && low_field == cod_pkg::MEM_DIRECT;
  wire logic [15:0] base_word    = base_q[15:0];
  wire logic [15:0] base_pointer = base_q[31:16];
  wire logic [15:0] source_index = index_q[15:0];
  wire logic [15:0] dest_index   = index_q[31:16];
  wire logic [15:0] accum_word   = accsp_q[15:0];
  wire logic [15:0] stack_ptr    = accsp_q[31:16];

  // ----------------------------------------------------------------
  // Decoded operand fields
  // ----------------------------------------------------------------
  cod_pkg::cod_dec_t dec_d;
  assign dec_d.size_word = size_bit;                           // [RULE_01]
  assign dec_d.imm16     = ({extend_bit, size_bit} == 2'b01)
                           || ({extend_bit, size_bit} == 2'b11); // [RULE_02]
  assign dec_d.is_mem    = is_mem;
  assign dec_d.direct    = is_direct;                          // [RULE_04]
  // Direct form always carries a full 16-bit address word
  assign dec_d.disp_len  = is_direct ? cod_pkg::MOD_DISP16
                         : (is_mem ? addr_form : 2'h0);        // [RULE_03]
  // Register code: {size, field}; size 0 walks the byte registers
  assign dec_d.gpr       = is_mem ? 4'h0 : {size_bit, low_field}; // [RULE_05]
  assign dec_d.seg       = cod_pkg::cod_seg_t'(mid_field[1:0]); // [RULE_06]

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  logic [15:0] ea_base;
  always_comb begin
    case (low_field)                                            // [RULE_04]
      3'h0:    ea_base = base_word + source_index;
      3'h1:    ea_base = base_word + dest_index;
      3'h2:    ea_base = base_pointer + source_index;
      3'h3:    ea_base = base_pointer + dest_index;
      3'h4:    ea_base = source_index;
      3'h5:    ea_base = dest_index;
      3'h6:    ea_base = is_direct ? 16'h0000 : base_pointer;
      default: ea_base = base_word;
    endcase
  end

  logic [15:0] ea_disp;
  always_comb begin
    case (addr_form)                                            // [RULE_03]
      cod_pkg::MOD_NODISP: ea_disp = is_direct ? disp_word : 16'h0000;
      cod_pkg::MOD_DISP8:  ea_disp = sext8(disp_word[7:0]);
      cod_pkg::MOD_DISP16: ea_disp = disp_word;
      default:             ea_disp = 16'h0000;
    endcase
  end
  wire logic [15:0] ea_d = ea_base + ea_disp;

  // Short branch: signed byte from the address after this instruction
  wire logic [15:0] target_d = nextpc_q[15:0]
                               + sext8(disp_word[7:0]);         // [RULE_11]

  // ----------------------------------------------------------------
  // Clock count
  // ----------------------------------------------------------------
  wire logic [7:0]  cnt_first  = clocks_q[7:0];
  wire logic [7:0]  cnt_second = clocks_q[15:8];
  wire logic [7:0]  cnt_stall  = clocks_q[23:16];
  wire logic [3:0]  odd_words  = clocks_q[27:24];
  logic [7:0] cnt_sel;
  // Branch choice outranks operand size for a conditional transfer
  always_comb begin
    if (ctrl_q[cod_pkg::CTRL_COND]) begin
      cnt_sel = ctrl_q[cod_pkg::CTRL_TAKEN]
                ? cnt_first : cnt_second;                       // [RULE_09]
    end else if (is_mem) begin
      cnt_sel = size_bit ? cnt_second : cnt_first;              // [RULE_08]
    end else begin
      cnt_sel = cnt_first;
    end
  end
  wire logic [15:0] odd_pen  = 16'(odd_words * cod_pkg::ODD_WORD_CLOCKS);
  // Stall time is added on top of the listed count, never folded in
  wire logic [15:0] cycles_d = 16'({8'h00, cnt_sel}) + odd_pen // [RULE_07]
                               + {8'h00, cnt_stall};            // [RULE_10]

  // ----------------------------------------------------------------
  // Table, stack and flag results
  // ----------------------------------------------------------------
  wire logic [15:0] lookup_d = base_word
                               + {8'h00, accum_word[7:0]};      // [RULE_14]
  wire logic [15:0] sp_after_d = stack_ptr + nextpc_q[31:16];   // [RULE_15]

  logic [5:0] flags_d;
  genvar gi;
  generate
    for (gi = 0; gi < cod_pkg::NUM_FLAGS; gi++) begin : g_flag
      // Undefined leaves the old bit: a defined value costs nothing
      assign flags_d[gi] = flag_apply(flags_cfg_q[3*gi +: 3],
                                      flags_q[gi],
                                      flags_cfg_q[18 + gi],
                                      flags_cfg_q[24 + gi]);    // [RULE_12]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (state_q)
      cod_pkg::ST_IDLE: state_d = go ? cod_pkg::ST_CALC : cod_pkg::ST_IDLE;
      cod_pkg::ST_CALC: state_d = cod_pkg::ST_DONE;
      cod_pkg::ST_DONE: state_d = go ? cod_pkg::ST_CALC : cod_pkg::ST_DONE;
      default:          state_d = cod_pkg::ST_IDLE;
    endcase
  end
  wire logic calc = state_q == cod_pkg::ST_CALC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cod_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  // The go bit is a request, so it never reads back as set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= cod_pkg::RST_WORD;
      opcode_q    <= cod_pkg::RST_WORD;
      base_q      <= cod_pkg::RST_WORD;
      index_q     <= cod_pkg::RST_WORD;
      accsp_q     <= cod_pkg::RST_WORD;
      clocks_q    <= cod_pkg::RST_WORD;
      nextpc_q    <= cod_pkg::RST_WORD;
      farptr_q    <= cod_pkg::RST_WORD;
      flags_cfg_q <= cod_pkg::RST_WORD;
    end else if (wr_en) begin
      case (paddr)
        cod_pkg::OFF_CTRL:   ctrl_q      <= {pwdata[31:1], 1'b0};
        cod_pkg::OFF_OPCODE: opcode_q    <= pwdata;
        cod_pkg::OFF_BASE:   base_q      <= pwdata;
        cod_pkg::OFF_INDEX:  index_q     <= pwdata;
        cod_pkg::OFF_ACCSP:  accsp_q     <= pwdata;
        cod_pkg::OFF_CLOCKS: clocks_q    <= pwdata;
        cod_pkg::OFF_NEXTPC: nextpc_q    <= pwdata;
        cod_pkg::OFF_FARPTR: farptr_q    <= pwdata;
        cod_pkg::OFF_FLAGS:  flags_cfg_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Float instruction: address goes out, returned data is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memdata_q <= cod_pkg::RST_WORD;
    end else if (wr_en && paddr == cod_pkg::OFF_MEMDATA
                 && !ctrl_q[cod_pkg::CTRL_FLOAT]) begin        // [RULE_19]
      memdata_q <= pwdata;
    end
  end

  // Scratch words; a far transfer loads offset and segment on decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_a_q <= 16'h0000;
      temp_b_q <= 16'h0000;
      temp_c_q <= 16'h0000;
    end else if (calc && ctrl_q[cod_pkg::CTRL_FAR]) begin
      temp_a_q <= farptr_q[15:0];                               // [RULE_17]
      temp_c_q <= farptr_q[31:16];                              // [RULE_13]
    end else if (wr_en && paddr == cod_pkg::OFF_TEMPAB) begin
      temp_a_q <= pwdata[15:0];
      temp_b_q <= pwdata[31:16];
    end else if (wr_en && paddr == cod_pkg::OFF_TEMPC) begin
      temp_c_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Decode results, captured in the calculation cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q      <= '0;
      ea_q       <= 16'h0000;
      target_q   <= 16'h0000;
      cycles_q   <= 16'h0000;
      lookup_q   <= 16'h0000;
      sp_after_q <= 16'h0000;
      flags_q    <= 6'h00;
    end else if (calc) begin
      dec_q      <= dec_d;
      ea_q       <= is_mem ? ea_d : 16'h0000;
      target_q   <= target_d;
      cycles_q   <= cycles_d;
      lookup_q   <= lookup_d;
      sp_after_q <= sp_after_d;
      flags_q    <= flags_d;
    end
  end

  // Float op bits leave raw: six field bits, no interpretation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_op_code <= 6'h00;
    end else if (calc && ctrl_q[cod_pkg::CTRL_FLOAT]) begin
      float_op_code <= {op_byte[2:0], mid_field};               // [RULE_18]
    end
  end

  assign dec_done = state_q == cod_pkg::ST_DONE;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata_mux;
  always_comb begin
    case (paddr)
      cod_pkg::OFF_CTRL:    rdata_mux = ctrl_q;
      cod_pkg::OFF_OPCODE:  rdata_mux = opcode_q;
      cod_pkg::OFF_BASE:    rdata_mux = base_q;
      cod_pkg::OFF_INDEX:   rdata_mux = index_q;
      cod_pkg::OFF_ACCSP:   rdata_mux = accsp_q;
      cod_pkg::OFF_CLOCKS:  rdata_mux = clocks_q;
      cod_pkg::OFF_NEXTPC:  rdata_mux = nextpc_q;
      cod_pkg::OFF_FARPTR:  rdata_mux = farptr_q;
      cod_pkg::OFF_TEMPAB:  rdata_mux = {temp_b_q, temp_a_q};
      cod_pkg::OFF_TEMPC:   rdata_mux = {16'h0000, temp_c_q};
      cod_pkg::OFF_FLAGS:   rdata_mux = flags_cfg_q;
      cod_pkg::OFF_MEMDATA: rdata_mux = memdata_q;
      cod_pkg::OFF_STATUS:  rdata_mux = {13'h0000, dec_done,
                                         float_op_code, dec_q};
      cod_pkg::OFF_EA:      rdata_mux = {target_q, ea_q};
      cod_pkg::OFF_CYCLES:  rdata_mux = {lookup_q, cycles_q};
      cod_pkg::OFF_STACK:   rdata_mux = {10'h000, flags_q, sp_after_q};
      cod_pkg::OFF_BLOCK:   rdata_mux = {dest_index, source_index}; // [RULE_16]
      default:              rdata_mux = 32'h0000_0000;
    endcase
  end
  assign prdata = rd_en ? rdata_mux : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_size_select: assert property ( // [RULE_01]
    calc |=> dec_q.size_word == $past(size_bit))
    else $error("size bit not captured");
  a_imm_width: assert property (calc && size_bit |=> dec_q.imm16) // [RULE_02]
    else $error("word size must give 16-bit immediate");
  a_reg_form: assert property ( // [RULE_03]
    calc && addr_form == cod_pkg::MOD_REG
    |=> !dec_q.is_mem && ea_q == 16'h0000)
    else $error("register form decoded as memory");
  a_direct_addr: assert property ( // [RULE_04]
    calc && is_direct |=> ea_q == $past(disp_word))
    else $error("direct address wrong");
  a_gpr_code: assert property ( // [RULE_05]
    calc && !is_mem |=> dec_q.gpr == $past({size_bit, low_field}))
    else $error("register code wrong");
  a_seg_map: assert property ( // [RULE_06]
    calc && mid_field[1:0] == 2'b10 |=> dec_q.seg == cod_pkg::SEG_STACK)
    else $error("segment code 10 not stack");
  a_branch_cnt: assert property ( // [RULE_09]
    calc && ctrl_q[cod_pkg::CTRL_COND] && !ctrl_q[cod_pkg::CTRL_TAKEN]
    && clocks_q[31:16] == 16'h0000
    |=> cycles_q == $past({8'h00, cnt_second}))
    else $error("fall-through count wrong");
  a_odd_penalty: assert property ( // [RULE_07]
    calc && !ctrl_q[cod_pkg::CTRL_COND] && !is_mem
    && clocks_q[23:16] == 8'h00
    |=> cycles_q == $past({8'h00, cnt_first})
        + 16'($past(odd_words)) * cod_pkg::ODD_WORD_CLOCKS)
    else $error("odd word penalty wrong");
  a_short_target: assert property ( // [RULE_11]
    calc |=> target_q == $past(nextpc_q[15:0] + sext8(disp_word[7:0])))
    else $error("short branch target wrong");
  a_float_drop: assert property ( // [RULE_19]
    wr_en && paddr == cod_pkg::OFF_MEMDATA && ctrl_q[cod_pkg::CTRL_FLOAT]
    |=> $stable(memdata_q))
    else $error("float cycle data accepted");
  a_go_done: assert property (go |=> calc ##1 dec_done)
    else $error("decode did not finish in two cycles");

  c_mem_word: cover property (calc && is_mem && size_bit);
  c_branch_taken: cover property (calc && ctrl_q[2] && ctrl_q[1]);
  c_far_load: cover property (calc && ctrl_q[4]);
  c_float_op: cover property (calc && ctrl_q[3]);

endmodule // cod_decoder

// ===== cod_fpu_model.sv
// Behavioural model of the external arithmetic chip watching op codes
`timescale 1ns/1ps
module cod_fpu_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Op code seen from the decoder
  input  wire logic [5:0] float_op_code,
  output logic      [5:0] seen_q
);
  // Takes the code as delivered; the chip alone interprets it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_q <= 6'h00;
    else seen_q <= float_op_code;
  end
endmodule // cod_fpu_model

// ===== tb.sv
// Self-checking bench for the operand decoder over APB
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dec_done;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [5:0] float_op_code, seen;
  logic e;
  int fails = 0, cmp_count = 0, cyc = 0;
  cod_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dec_done(dec_done), .float_op_code(float_op_code));
  cod_fpu_model fpu (.pclk(pclk), .presetn(presetn),
    .float_op_code(float_op_code), .seen_q(seen));
  // ----------------------------------------------------------------
  // Clock, timeout and closing report
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Bus cycle and compare helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  // Loads opcode and counts, starts a decode, waits out the latency
  task run(input logic [31:0] op, input logic [31:0] ct,
           input logic [31:0] ck);
    apb(1'b1, cod_pkg::OFF_OPCODE, op);
    apb(1'b1, cod_pkg::OFF_CLOCKS, ck);
    apb(1'b1, cod_pkg::OFF_CTRL, ct | 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk("done", 1'b1, dec_done);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_mem;
    apb(1'b1, cod_pkg::OFF_BASE, 32'h0200_1000);
    apb(1'b1, cod_pkg::OFF_INDEX, 32'h0030_0004);
    run(32'h0010_8001, 32'h0, 32'h0100_0F0B);
    apb(1'b0, cod_pkg::OFF_STATUS, 32'h0);
    chk("dec_word", 6'h3A, r[11:6]);
    apb(1'b0, cod_pkg::OFF_EA, 32'h0);
    chk("ea", 16'h1014, r[15:0]);
    apb(1'b0, cod_pkg::OFF_CYCLES, 32'h0);
    chk("clk_word", 16'h0013, r[15:0]);
    apb(1'b0, cod_pkg::OFF_BLOCK, 32'h0);
    chk("block", 32'h0030_0004, r);
    run(32'h0010_8002, 32'h0, 32'h0002_0F0B);
    apb(1'b0, cod_pkg::OFF_STATUS, 32'h0);
    chk("dec_byte", 6'h0A, r[11:6]);
    apb(1'b0, cod_pkg::OFF_CYCLES, 32'h0);
    chk("clk_byte", 16'h000D, r[15:0]);
    $display("test mem done");
  endtask
  task t_form;
    run(32'h1234_0601, 32'h0, 32'h0);
    apb(1'b0, cod_pkg::OFF_STATUS, 32'h0);
    chk("direct", 4'hE, r[9:6]);
    apb(1'b0, cod_pkg::OFF_EA, 32'h0);
    chk("ea_dir", 16'h1234, r[15:0]);
    apb(1'b1, cod_pkg::OFF_NEXTPC, 32'h0000_0100);
    run(32'h0080_C000, 32'h0, 32'h0);
    apb(1'b0, cod_pkg::OFF_EA, 32'h0);
    chk("reg_ea", 32'h0080_0000, r);
    $display("test form done");
  endtask
  task t_branch;
    run(32'h0000_C000, 32'h6, 32'h0000_0410);
    apb(1'b0, cod_pkg::OFF_CYCLES, 32'h0);
    chk("taken", 16'h0010, r[15:0]);
    run(32'h0000_C000, 32'h4, 32'h0000_0410);
    apb(1'b0, cod_pkg::OFF_CYCLES, 32'h0);
    chk("fall", 16'h0004, r[15:0]);
    $display("test branch done");
  endtask
  task t_float;
    apb(1'b1, cod_pkg::OFF_MEMDATA, 32'h0000_1111);
    run(32'h0000_1805, 32'h8, 32'h0);
    chk("fp_code", 6'h2B, seen);
    apb(1'b1, cod_pkg::OFF_MEMDATA, 32'h0000_2222);
    apb(1'b0, cod_pkg::OFF_MEMDATA, 32'h0);
    chk("memdata", 32'h0000_1111, r);
    $display("test float done");
  endtask
  // Scratch words, far pointer load, lookup, stack discard and flags
  task t_misc;
    apb(1'b1, cod_pkg::OFF_TEMPAB, 32'h3333_2222);
    apb(1'b1, cod_pkg::OFF_TEMPC, 32'h0000_4444);
    apb(1'b0, cod_pkg::OFF_TEMPAB, 32'h0);
    chk("temp_ab", 32'h3333_2222, r);
    apb(1'b0, cod_pkg::OFF_TEMPC, 32'h0);
    chk("temp_c", 32'h0000_4444, r);
    apb(1'b1, cod_pkg::OFF_FARPTR, 32'hABCD_1234);
    apb(1'b1, cod_pkg::OFF_BASE, 32'h0000_1000);
    apb(1'b1, cod_pkg::OFF_ACCSP, 32'h0100_0057);
    apb(1'b1, cod_pkg::OFF_NEXTPC, 32'h0006_0000);
    apb(1'b1, cod_pkg::OFF_FLAGS, 32'h0001_2492);
    run(32'h0000_C000, 32'h10, 32'h0);
    apb(1'b0, cod_pkg::OFF_TEMPAB, 32'h0);
    chk("far_off", 32'h3333_1234, r);
    apb(1'b0, cod_pkg::OFF_TEMPC, 32'h0);
    chk("far_seg", 32'h0000_ABCD, r);
    apb(1'b0, cod_pkg::OFF_CYCLES, 32'h0);
    chk("lookup", 32'h1057_0000, r);
    apb(1'b0, cod_pkg::OFF_STACK, 32'h0);
    chk("flags_set", 32'h003F_0106, r);
    apb(1'b1, cod_pkg::OFF_FLAGS, 32'h2002_CAC8);
    run(32'h0000_C000, 32'h0, 32'h0);
    apb(1'b0, cod_pkg::OFF_STACK, 32'h0);
    chk("flags_mix", 32'h0031_0106, r);
    $display("test misc done");
  endtask
  task t_bad;
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped_err", 1'b1, e);
    chk("unmapped_rd", 32'h0, r);
    apb(1'b1, 8'h02, 32'hFFFF_FFFF);
    chk("misalign", 1'b1, e);
    $display("test bad done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, cod_pkg::OFF_STATUS, 32'h0);
    chk("rst_status", 32'h0, r);
    t_mem;
    t_form;
    t_branch;
    t_float;
    t_misc;
    t_bad;
    end_sim;
  end
endmodule // tb
